// ==== hdl/psa_pkg.sv ====
// Summary of operation
// - Four-bit legacy status codes per port
// - Legacy enable forces status zero until measured
// - Legacy result held in every mode
// - Measure only when legacy detect enabled
// - One result count equals 4.884 uV
// - Auto mode: detect, classify, power, protect
// - Power-off or disconnect while powered, with no fault in that cycle, restarts detection at once
// - Fault shutdown waits cool-down, then detects
// - Power only after valid detect and class
// - Address 0x20 strap low, else 0x28
// - Overload-cut threshold set from class in the same cycle that power turns on
// - High byte: status above result bits 11..8
package psa_pkg;
	localparam int       NUM_PORTS        = 4;
	localparam int       CLK_MHZ          = 125;
	localparam int       COOL_MS          = 1000;
	localparam int       COOL_CYCLES      = COOL_MS * CLK_MHZ * 1000;
	localparam int       DV_STEP_UV_X1000 = 4884;
	localparam logic [6:0] ADDR_STRAP_LOW  = 7'h20;
	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h28;
	localparam logic [7:0] REG_POWER_STATUS = 8'h10;
	localparam logic [7:0] REG_MODE         = 8'h12;
	localparam logic [7:0] REG_LEGACY_CFG   = 8'h13;
	localparam logic [7:0] REG_DV_BASE      = 8'h68;
	localparam logic [7:0] REG_RESERVED_A   = 8'h1B;
	localparam logic [7:0] REG_RESERVED_B   = 8'h1D;
	localparam logic [7:0] REG_RESERVED_C   = 8'h1E;
	localparam logic [7:0] REG_RESERVED_D   = 8'h1F;
	localparam logic [7:0] REG_RESERVED_E   = 8'h22;
	localparam logic [7:0] REG_RESERVED_F   = 8'h23;
	localparam logic [7:0] REG_RESERVED_G   = 8'h24;
	localparam logic [7:0] REG_RESERVED_H   = 8'h25;
	localparam logic [7:0] REG_RESERVED_I   = 8'h59;
	localparam logic [7:0] MODE_RST         = 8'hFF;
	localparam logic [7:0] LEGACY_CFG_RST   = 8'h00;
	localparam logic [1:0] MODE_AUTO        = 2'h3;
	localparam logic [3:0] LG_RESET         = 4'h0;
	localparam logic [3:0] LG_VALID         = 4'h1;
	localparam logic [3:0] LG_DISCH_TIMEOUT = 4'h2;
	localparam logic [3:0] LG_LOW_TIMEOUT   = 4'h3;
	localparam logic [3:0] LG_CLAMP_FIRST   = 4'h4;
	localparam logic [3:0] LG_CLAMP_SECOND  = 4'h5;
	localparam logic [3:0] LG_LOW_SWING     = 4'h6;
	localparam logic [2:0] CLASS_MAX        = 3'h4;
	typedef enum logic [2:0] {ST_IDLE, ST_DETECT, ST_CLASS, ST_POWER, ST_COOL} psa_state_t;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_WR, I_RD, I_RACK} psa_i2c_t;
endpackage

// ==== hdl/psa_port_seq.sv ====
`timescale 1ns/100ps
module psa_port_seq #(
	parameter int COOL_CYCLES = psa_pkg::COOL_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        auto_en,
	input  wire logic        legacy_en,
	input  wire logic        det_done,
	input  wire logic        det_valid,
	input  wire logic        cls_done,
	input  wire logic [2:0]  cls_class,
	input  wire logic        cls_bad,
	input  wire logic        fault_start,
	input  wire logic        fault_cut,
	input  wire logic        fault_lim,
	input  wire logic        disconnect,
	input  wire logic        power_off_cmd,
	input  wire logic        meas_done,
	input  wire logic [3:0]  meas_status,
	input  wire logic [11:0] meas_dv,
	output logic             det_start,
	output logic             cls_start,
	output logic             meas_req,
	output logic             power_en,
	output logic [2:0]       overload_cut_threshold,
	output logic [3:0]       legacy_dv_status,
	output logic [11:0]      legacy_dv_result
);
	psa_pkg::psa_state_t state_r, state_nxt;
	logic [31:0] cool_r, cool_nxt;
	logic [2:0]  cut_r, cut_nxt;
	logic [3:0]  lst_r, lst_nxt;
	logic [11:0] ldv_r, ldv_nxt;
	logic        len_r;

	always_comb
	begin
		state_nxt = state_r;
		cool_nxt  = cool_r;
		cut_nxt   = cut_r;
		case (state_r)
			psa_pkg::ST_IDLE:
				if (auto_en)
					state_nxt = psa_pkg::ST_DETECT;
			psa_pkg::ST_DETECT:
				if (det_done && det_valid)
					state_nxt = psa_pkg::ST_CLASS;
			psa_pkg::ST_CLASS:
				if (cls_done)
				begin
					// Class above four counts as unknown in auto mode
					if (cls_bad || cls_class > psa_pkg::CLASS_MAX)
						state_nxt = psa_pkg::ST_DETECT;
					else
					begin
						cut_nxt   = cls_class;
						state_nxt = psa_pkg::ST_POWER;
					end
				end
			psa_pkg::ST_POWER:
				if (fault_start || fault_cut || fault_lim)
				begin
					cool_nxt  = 32'h0;
					state_nxt = psa_pkg::ST_COOL;
				end
				else if (power_off_cmd || disconnect)
					state_nxt = psa_pkg::ST_DETECT;
			psa_pkg::ST_COOL:
				if (cool_r >= 32'(COOL_CYCLES - 1))
					state_nxt = psa_pkg::ST_DETECT;
				else
					cool_nxt = cool_r + 32'h1;
			default:
				state_nxt = psa_pkg::ST_IDLE;
		endcase
		if (!auto_en)
			state_nxt = psa_pkg::ST_IDLE;
	end

	always_comb
	begin
		lst_nxt = lst_r;
		ldv_nxt = ldv_r;
		if (legacy_en && !len_r)
			lst_nxt = psa_pkg::LG_RESET;
		// A result landing on the enable edge still wins
		if (legacy_en && meas_done)
		begin
			lst_nxt = meas_status;
			ldv_nxt = meas_dv;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_r <= psa_pkg::ST_IDLE;
			cool_r  <= 32'h0;
			cut_r   <= 3'h0;
			lst_r   <= psa_pkg::LG_RESET;
			ldv_r   <= 12'h000;
			len_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cool_r  <= cool_nxt;
			cut_r   <= cut_nxt;
			lst_r   <= lst_nxt;
			ldv_r   <= ldv_nxt;
			len_r   <= legacy_en;
		end
	end

	assign det_start              = state_r == psa_pkg::ST_DETECT;
	assign cls_start              = state_r == psa_pkg::ST_CLASS;
	assign meas_req               = legacy_en && state_r == psa_pkg::ST_DETECT;
	assign power_en               = state_r == psa_pkg::ST_POWER;
	assign overload_cut_threshold = cut_r;
	assign legacy_dv_status       = lst_r;
	assign legacy_dv_result       = ldv_r;
endmodule

// ==== hdl/psa_top.sv ====
`timescale 1ns/100ps
module psa_top #(
	parameter int NP          = psa_pkg::NUM_PORTS,
	parameter int COOL_CYCLES = psa_pkg::COOL_CYCLES
) (
	input  wire logic           ref_clk,
	input  wire logic           srst,
	input  wire logic           scl_in,
	input  wire logic           sda_in,
	output logic                sda_out,
	output logic                sda_oe,
	input  wire logic           address_select_strap,
	input  wire logic [NP-1:0]  det_done,
	input  wire logic [NP-1:0]  det_valid,
	input  wire logic [NP-1:0]  cls_done,
	input  wire logic [3*NP-1:0] cls_class,
	input  wire logic [NP-1:0]  cls_bad,
	input  wire logic [NP-1:0]  fault_start,
	input  wire logic [NP-1:0]  fault_cut,
	input  wire logic [NP-1:0]  fault_lim,
	input  wire logic [NP-1:0]  disconnect,
	input  wire logic [NP-1:0]  power_off_cmd,
	input  wire logic [NP-1:0]  meas_done,
	input  wire logic [4*NP-1:0] meas_status,
	input  wire logic [12*NP-1:0] meas_dv,
	output logic [NP-1:0]       det_start,
	output logic [NP-1:0]       cls_start,
	output logic [NP-1:0]       meas_req,
	output logic [NP-1:0]       power_en,
	output logic [3*NP-1:0]     overload_cut_threshold
);
	logic [4*NP-1:0]  lg_status;
	logic [12*NP-1:0] lg_result;
	logic       scl_s1_r, scl_s2_r, scl_d_r;
	logic       sda_s1_r, sda_s2_r, sda_d_r;
	logic       strap_s1_r, strap_s2_r, strap_taken_r;
	logic [6:0] dev_addr_r;
	psa_pkg::psa_i2c_t ist_r, ist_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic       rw_r, rw_nxt;
	logic       first_r, first_nxt;
	logic       oe_r, oe_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic [7:0] mode_r, mode_nxt;
	logic [7:0] lgcfg_r, lgcfg_nxt;
	logic [7:0] snap_r, snap_nxt;
	logic [7:0] rd_data;
	logic       scl_rise, scl_fall, bus_start, bus_stop;

	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++)
		begin : g_port
			psa_port_seq #(.COOL_CYCLES(COOL_CYCLES)) u_seq (
				.ref_clk                (ref_clk),
				.srst                   (srst),
				.auto_en                (mode_r[2*gp+:2] == psa_pkg::MODE_AUTO),
				.legacy_en              (lgcfg_r[gp]),
				.det_done               (det_done[gp]),
				.det_valid              (det_valid[gp]),
				.cls_done               (cls_done[gp]),
				.cls_class              (cls_class[3*gp+:3]),
				.cls_bad                (cls_bad[gp]),
				.fault_start            (fault_start[gp]),
				.fault_cut              (fault_cut[gp]),
				.fault_lim              (fault_lim[gp]),
				.disconnect             (disconnect[gp]),
				.power_off_cmd          (power_off_cmd[gp]),
				.meas_done              (meas_done[gp]),
				.meas_status            (meas_status[4*gp+:4]),
				.meas_dv                (meas_dv[12*gp+:12]),
				.det_start              (det_start[gp]),
				.cls_start              (cls_start[gp]),
				.meas_req               (meas_req[gp]),
				.power_en               (power_en[gp]),
				.overload_cut_threshold (overload_cut_threshold[3*gp+:3]),
				.legacy_dv_status       (lg_status[4*gp+:4]),
				.legacy_dv_result       (lg_result[12*gp+:12])
			);
		end
	endgenerate

	function automatic logic [7:0] dv_addr(input int p, input logic hi);
		dv_addr = psa_pkg::REG_DV_BASE + 8'(2 * p) + {7'h00, hi};
	endfunction

	assign scl_rise  = scl_s2_r && !scl_d_r;
	assign scl_fall  = !scl_s2_r && scl_d_r;
	assign bus_start = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
	assign bus_stop  = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

	// High byte is frozen when its low byte is fetched, so a pair reads coherently
	always_comb
	begin
		rd_data  = 8'h00;
		snap_nxt = snap_r;
		if (ptr_r == psa_pkg::REG_MODE)
			rd_data = mode_r;
		if (ptr_r == psa_pkg::REG_LEGACY_CFG)
			rd_data = lgcfg_r;
		if (ptr_r == psa_pkg::REG_POWER_STATUS)
			rd_data = 8'(power_en);
		for (int p = 0; p < NP; p++)
		begin
			if (ptr_r == dv_addr(p, 1'b0))
			begin
				rd_data  = lg_result[12*p+:8];
				snap_nxt = {lg_status[4*p+:4], lg_result[12*p+8+:4]};
			end
			if (ptr_r == dv_addr(p, 1'b1))
				rd_data = snap_r;
		end
	end

	always_comb
	begin
		ist_nxt   = ist_r;
		sh_nxt    = sh_r;
		cnt_nxt   = cnt_r;
		rw_nxt    = rw_r;
		first_nxt = first_r;
		oe_nxt    = oe_r;
		ptr_nxt   = ptr_r;
		mode_nxt  = mode_r;
		lgcfg_nxt = lgcfg_r;
		if (bus_start)
		begin
			ist_nxt = psa_pkg::I_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end
		else if (bus_stop)
		begin
			ist_nxt = psa_pkg::I_IDLE;
			oe_nxt  = 1'b0;
		end
		else
		begin
			case (ist_r)
				psa_pkg::I_IDLE:
					oe_nxt = 1'b0;
				psa_pkg::I_ADDR, psa_pkg::I_WR:
					if (scl_rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_s2_r};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (scl_fall && cnt_r == 4'h8)
					begin
						if (ist_r == psa_pkg::I_ADDR)
						begin
							if (sh_r[7:1] == dev_addr_r)
							begin
								rw_nxt    = sh_r[0];
								first_nxt = !sh_r[0];
								oe_nxt    = 1'b1;
								ist_nxt   = psa_pkg::I_ACK;
							end
							else
								ist_nxt = psa_pkg::I_IDLE;
						end
						else
						begin
							// Reserved locations are simply not decoded
							if (first_r)
								ptr_nxt = sh_r;
							else
							begin
								if (ptr_r == psa_pkg::REG_MODE)
									mode_nxt = sh_r;
								if (ptr_r == psa_pkg::REG_LEGACY_CFG)
									lgcfg_nxt = {4'h0, sh_r[3:0]};
								ptr_nxt = ptr_r + 8'h01;
							end
							first_nxt = 1'b0;
							oe_nxt    = 1'b1;
							ist_nxt   = psa_pkg::I_ACK;
						end
					end
				psa_pkg::I_ACK:
					if (scl_fall)
					begin
						if (rw_r)
						begin
							oe_nxt  = !rd_data[7];
							sh_nxt  = {rd_data[6:0], 1'b0};
							cnt_nxt = 4'h1;
							ptr_nxt = ptr_r + 8'h01;
							ist_nxt = psa_pkg::I_RD;
						end
						else
						begin
							oe_nxt  = 1'b0;
							cnt_nxt = 4'h0;
							ist_nxt = psa_pkg::I_WR;
						end
					end
				psa_pkg::I_RD:
					if (scl_fall)
					begin
						if (cnt_r == 4'h8)
						begin
							oe_nxt  = 1'b0;
							ist_nxt = psa_pkg::I_RACK;
						end
						else
						begin
							oe_nxt  = !sh_r[7];
							sh_nxt  = {sh_r[6:0], 1'b0};
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				psa_pkg::I_RACK:
					if (scl_rise)
						ist_nxt = sda_s2_r ? psa_pkg::I_IDLE : psa_pkg::I_ACK;
				default:
					ist_nxt = psa_pkg::I_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		// Strap synchroniser runs through reset, so the capture after release sees the pin
		strap_s1_r <= address_select_strap;
		strap_s2_r <= strap_s1_r;
		if (srst)
		begin
			scl_s1_r      <= 1'b1;
			scl_s2_r      <= 1'b1;
			scl_d_r       <= 1'b1;
			sda_s1_r      <= 1'b1;
			sda_s2_r      <= 1'b1;
			sda_d_r       <= 1'b1;
			strap_taken_r <= 1'b0;
			dev_addr_r    <= psa_pkg::ADDR_STRAP_HIGH;
			ist_r         <= psa_pkg::I_IDLE;
			sh_r          <= 8'h00;
			cnt_r         <= 4'h0;
			rw_r          <= 1'b0;
			first_r       <= 1'b0;
			oe_r          <= 1'b0;
			ptr_r         <= 8'h00;
			mode_r        <= psa_pkg::MODE_RST;
			lgcfg_r       <= psa_pkg::LEGACY_CFG_RST;
			snap_r        <= 8'h00;
		end
		else
		begin
			scl_s1_r   <= scl_in;
			scl_s2_r   <= scl_s1_r;
			scl_d_r    <= scl_s2_r;
			sda_s1_r   <= sda_in;
			sda_s2_r   <= sda_s1_r;
			sda_d_r    <= sda_s2_r;
			// Strap is sampled once after the synchroniser has filled
			if (!strap_taken_r)
			begin
				strap_taken_r <= 1'b1;
				dev_addr_r    <= strap_s2_r ? psa_pkg::ADDR_STRAP_HIGH
				                            : psa_pkg::ADDR_STRAP_LOW;
			end
			ist_r   <= ist_nxt;
			sh_r    <= sh_nxt;
			cnt_r   <= cnt_nxt;
			rw_r    <= rw_nxt;
			first_r <= first_nxt;
			oe_r    <= oe_nxt;
			ptr_r   <= ptr_nxt;
			mode_r  <= mode_nxt;
			lgcfg_r <= lgcfg_nxt;
			if (ist_r == psa_pkg::I_ACK && rw_r && scl_fall)
				snap_r <= snap_nxt;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_r;
endmodule

// ==== testbench/psa_top_asserts.sv ====
`timescale 1ns/100ps
module psa_top_asserts #(
	parameter int NP          = 4,
	parameter int COOL_CYCLES = 20
) (
	input wire logic            ref_clk,
	input wire logic            srst,
	input wire logic [NP-1:0]   det_done,
	input wire logic [NP-1:0]   det_valid,
	input wire logic [NP-1:0]   cls_done,
	input wire logic [3*NP-1:0] cls_class,
	input wire logic [NP-1:0]   cls_bad,
	input wire logic [NP-1:0]   fault_start,
	input wire logic [NP-1:0]   fault_cut,
	input wire logic [NP-1:0]   fault_lim,
	input wire logic [NP-1:0]   disconnect,
	input wire logic [NP-1:0]   power_off_cmd,
	input wire logic [NP-1:0]   meas_req,
	input wire logic [NP-1:0]   det_start,
	input wire logic [NP-1:0]   cls_start,
	input wire logic [NP-1:0]   power_en,
	input wire logic [3*NP-1:0] overload_cut_threshold
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic flt;
	logic cool_r;
	logic cool_nxt;
	int   cnt_r;
	int   cnt_nxt;
	assign flt = power_en[0] && (fault_start[0] || fault_cut[0] || fault_lim[0]);
	// Counts cycles since a fault so the cool-down length is pinned exactly
	always_comb
	begin
		cool_nxt = flt || (cool_r && !det_start[0]);
		cnt_nxt  = flt ? 1 : cnt_r + 1;
	end
	always_ff @(posedge ref_clk)
	begin
		cool_r <= srst ? 1'b0 : cool_nxt;
		cnt_r  <= srst ? 0 : cnt_nxt;
	end
	sequence s_det_ok;
		det_start[0] && det_done[0] && det_valid[0];
	endsequence
	sequence s_cls_ok;
		cls_start[0] && cls_done[0] && !cls_bad[0] && cls_class[2:0] <= 3'h4;
	endsequence
	a_detect_to_class: assert property (s_det_ok |=> cls_start[0] && !det_start[0])
		else $error("class not entered");
	a_invalid_stays: assert property (det_start[0] && det_done[0] && !det_valid[0]
		|=> det_start[0] && !cls_start[0]) else $error("left detect");
	a_class_refused: assert property (cls_start[2] && cls_done[2]
		&& (cls_bad[2] || cls_class[8:6] > 3'h4) |=> det_start[2] && !power_en[2])
		else $error("bad class powered");
	a_class_to_power: assert property (s_cls_ok |=> power_en[0]
		&& overload_cut_threshold[2:0] == $past(cls_class[2:0])) else $error("threshold");
	a_fault_quiet: assert property (flt |=> (!power_en[0] && !det_start[0]) [*8])
		else $error("no cool-down");
	a_cool_exact: assert property (cool_r && det_start[0] |-> cnt_r == COOL_CYCLES + 1)
		else $error("cool-down length");
	a_off_redetect: assert property (power_en[0] && !flt
		&& (disconnect[0] || power_off_cmd[0]) |=> det_start[0]) else $error("no redetect");
	a_meas_in_detect: assert property (meas_req[0] |-> det_start[0])
		else $error("measure outside detect");
endmodule

// ==== testbench/psa_load_model.sv ====
`timescale 1ns/100ps
module psa_load_model #(
	parameter int DLY = 6
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [3:0]  det_start,
	input  wire logic [3:0]  cls_start,
	input  wire logic [3:0]  meas_req,
	input  wire logic [3:0]  ok,
	input  wire logic [3:0]  bad,
	input  wire logic [11:0] cls_in,
	input  wire logic [3:0]  mgo,
	input  wire logic [15:0] mst,
	input  wire logic [47:0] mdv,
	output logic      [3:0]  det_done,
	output logic      [3:0]  det_valid,
	output logic      [3:0]  cls_done,
	output logic      [11:0] cls_class,
	output logic      [3:0]  cls_bad,
	output logic      [3:0]  meas_done,
	output logic      [15:0] meas_status,
	output logic      [47:0] meas_dv
);
	for (genvar p = 0; p < 4; p++)
	begin : g_port
		logic [3:0] cnt_r;
		logic       act;
		logic       hit;
		assign act = det_start[p] || cls_start[p];
		assign hit = act && cnt_r == 4'(DLY);
		always_ff @(posedge ref_clk)
			cnt_r <= (srst || hit || !act) ? 4'h0 : cnt_r + 4'h1;
		// One pulse per settle time
		assign det_done[p]  = hit && det_start[p];
		assign cls_done[p]  = hit && cls_start[p];
		assign meas_done[p] = hit && meas_req[p] && mgo[p];
		// Qualifiers flip outside their pulse so late sampling shows up
		assign det_valid[p] = ok[p] ^ !det_done[p];
		assign cls_bad[p]   = bad[p] ^ !cls_done[p];
		assign cls_class[3*p +: 3]    = cls_in[3*p +: 3] ^ {3{!cls_done[p]}};
		assign meas_status[4*p +: 4]  = mst[4*p +: 4] ^ {4{!meas_done[p]}};
		assign meas_dv[12*p +: 12]    = mdv[12*p +: 12] ^ {12{!meas_done[p]}};
	end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
	localparam int COOL = 20;
	logic        ref_clk = 1'h0, srst = 1'h1, scl = 1'h1, sda_h = 1'h1, strap = 1'h0, a;
	logic [4:0]  ev = 5'h0;
	logic [3:0]  ok = 4'hF, bad = 4'h8, mgo = 4'h0;
	logic [11:0] cls_in = 12'h363;
	logic [15:0] mst = 16'h0;
	logic [47:0] mdv = 48'hABC;
	logic [3:0]  det_done, det_valid, cls_done, cls_bad, meas_done;
	logic [3:0]  det_start, cls_start, meas_req, power_en;
	logic [11:0] cls_class, overload_cut_threshold;
	logic [15:0] meas_status;
	logic [47:0] meas_dv;
	logic        sda_oe, sda_in, sda_o;
	logic [7:0]  lo, hi;
	int          err_count = 0, compares = 0;
	always #4 ref_clk = ~ref_clk;
	// Open-drain line with pull-up
	assign sda_in = sda_h & (~sda_oe | sda_o);
	psa_top #(.COOL_CYCLES(COOL)) uut (.ref_clk, .srst, .scl_in(scl), .sda_in, .sda_out(sda_o),
		.sda_oe, .address_select_strap(strap), .det_done, .det_valid, .cls_done, .cls_class,
		.cls_bad, .fault_start({3'h0, ev[0]}), .fault_cut({3'h0, ev[1]}),
		.fault_lim({3'h0, ev[2]}), .disconnect({3'h0, ev[3]}), .power_off_cmd({3'h0, ev[4]}),
		.meas_done, .meas_status, .meas_dv, .det_start, .cls_start, .meas_req, .power_en,
		.overload_cut_threshold);
	psa_load_model load (.ref_clk, .srst, .det_start, .cls_start, .meas_req, .ok, .bad,
		.cls_in, .mgo, .mst, .mdv, .det_done, .det_valid, .cls_done, .cls_class, .cls_bad,
		.meas_done, .meas_status, .meas_dv);
	task automatic test_done;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_h = b;
		tick(8);
		scl = 1'h1;
		tick(8);
		r = sda_in;
		scl = 1'h0;
		tick(2);
	endtask
	task automatic start;
		sda_h = 1'h1;
		tick(4);
		scl = 1'h1;
		tick(8);
		sda_h = 1'h0;
		tick(8);
		scl = 1'h0;
		tick(2);
	endtask
	task automatic stop;
		sda_h = 1'h0;
		tick(4);
		scl = 1'h1;
		tick(8);
		sda_h = 1'h1;
		tick(8);
	endtask
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(m, k);
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		start();
		xfer(8'h40, 1'h1, q, k);
		`CHK(k, 1'h0)
		xfer(r, 1'h1, q, k);
		xfer(d, 1'h1, q, k);
		stop();
	endtask
	task automatic rd2(input logic [7:0] r);
		logic [7:0] q;
		logic       k;
		start();
		xfer(8'h40, 1'h1, q, k);
		xfer(r, 1'h1, q, k);
		start();
		xfer(8'h41, 1'h1, q, k);
		xfer(8'hFF, 1'h0, lo, k);
		xfer(8'hFF, 1'h1, hi, k);
		stop();
	endtask
	task automatic wait_up(input logic k);
		int n;
		n = 0;
		while ((k ? power_en[0] : det_start[0]) !== 1'h1 && n < 300)
		begin
			tick(1);
			n++;
		end
		if (n == 300)
		begin
			err_count++;
			test_done();
		end
	endtask
	task automatic pulse(input int f);
		ev = 5'h1 << f;
		tick(1);
		ev = 5'h0;
	endtask
	initial
	begin
		tick(5);
		`CHK(power_en, 4'h0)
		srst = 1'h0;
		wait_up(1'h1);
		tick(20);
		`CHK(power_en, 4'h3)
		`CHK(overload_cut_threshold[5:0], 6'h23)
		rd2(8'h10);
		`CHK(lo, 8'h03)
		for (int f = 0; f < 5; f++)
		begin
			pulse(f);
			if (f < 3)
			begin
				tick(COOL - 4);
				`CHK({power_en[1:0], det_start[0]}, 3'h4)
				wait_up(1'h0);
			end
			else
				`CHK(det_start[0], 1'h1)
			wait_up(1'h1);
		end
		start();
		xfer(8'h50, 1'h1, lo, a);
		stop();
		`CHK(a, 1'h1)
		wr(8'h12, 8'hFC);
		tick(4);
		`CHK({power_en[1:0], det_start[0], cls_start[0]}, 4'h8)
		rd2(8'h1B);
		`CHK(lo, 8'h00)
		// Port 0 then fails detection and sits in detect for the measurements
		ok = 4'hE;
		wr(8'h12, 8'hFF);
		tick(4);
		`CHK(meas_req, 4'h0)
		wr(8'h13, 8'h01);
		`CHK(meas_req, 4'h1)
		for (int c = 1; c < 7; c++)
		begin
			mst[3:0] = 4'(c);
			mgo = 4'h1;
			tick(10);
			mgo = 4'h0;
			rd2(8'h68);
			`CHK(hi, {4'(c), 4'hA})
			if (c == 1)
				`CHK(lo, 8'hBC)
		end
		wr(8'h12, 8'hFC);
		rd2(8'h68);
		`CHK(hi, 8'h6A)
		wr(8'h12, 8'hFF);
		wr(8'h13, 8'h00);
		wr(8'h13, 8'h01);
		rd2(8'h68);
		`CHK(hi[7:4], 4'h0)
		// Second reset with the strap high moves the device to the other address
		strap = 1'h1;
		srst  = 1'h1;
		tick(5);
		`CHK(power_en, 4'h0)
		srst = 1'h0;
		tick(4);
		`CHK(meas_req, 4'h0)
		start();
		xfer(8'h50, 1'h1, lo, a);
		stop();
		`CHK(a, 1'h0)
		start();
		xfer(8'h40, 1'h1, lo, a);
		stop();
		`CHK(a, 1'h1)
		test_done();
	end
endmodule
bind psa_top psa_top_asserts #(.NP(NP), .COOL_CYCLES(COOL_CYCLES)) chk (.ref_clk, .srst,
	.det_done, .det_valid, .cls_done, .cls_class, .cls_bad, .fault_start, .fault_cut,
	.fault_lim, .disconnect, .power_off_cmd, .meas_req, .det_start, .cls_start, .power_en,
	.overload_cut_threshold);
